/* core/sam_alert_mask.sv */
// Purpose: alert masks for comm/logic, other and vendor status groups
// Assumes: command, status and memory ports come from same-clock logic
// Notes: alert output is active high; pin driver lives elsewhere
`timescale 1ns/100ps
module sam_alert_mask (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic cmdStb,
  input wire logic cmdWr,
  input wire logic [7:0] cmdCode,
  input wire logic [7:0] cmdSel,
  input wire logic [7:0] cmdData,
  input wire logic [7:0] commLogicStatus,
  input wire logic [7:0] vendorStatus,
  input wire logic nvmLoad,
  input wire logic [7:0] nvmCmlData,
  input wire logic [7:0] nvmMfrData,
  input wire logic nvmStore,
  output logic rdValid_r,
  output logic [7:0] rdData_r,
  output logic cmdNack_r,
  output logic storeValid_r,
  output logic [7:0] storeCml_r,
  output logic [7:0] storeMfr_r,
  output logic alert_r
);
  // ************************************
  // decode
  // ************************************
  sam_pkg::sam_sel_t sel;
  logic cmlWr;
  logic mfrWr;
  logic rdReq;
  logic [7:0] cmlMask_r;
  logic [7:0] mfrMask_r;
  logic [7:0] rdData_nxt;
  logic alert_nxt;

  assign sel = sam_pkg::decodeSel(cmdCode, cmdSel);
  assign cmlWr = cmdStb && cmdWr && (sel == sam_pkg::SEL_CML);
  assign mfrWr = cmdStb && cmdWr && (sel == sam_pkg::SEL_MFR);
  assign rdReq = cmdStb && !cmdWr;

  // ************************************
  // mask registers
  // ************************************
  sam_mask_reg #(
    .WR_MASK(sam_pkg::CML_WR_MASK),
    .RST_VAL(sam_pkg::CML_RST)
  ) uCml (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wrEn(cmlWr),
    .wrData(cmdData),
    .ldEn(nvmLoad),
    .ldData(nvmCmlData),
    .value_r(cmlMask_r)
  );

  sam_mask_reg #(
    .WR_MASK(sam_pkg::MFR_WR_MASK),
    .RST_VAL(sam_pkg::MFR_RST)
  ) uMfr (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wrEn(mfrWr),
    .wrData(cmdData),
    .ldEn(nvmLoad),
    .ldData(nvmMfrData),
    .value_r(mfrMask_r)
  );

  // ************************************
  // read back
  // ************************************
  always_comb
  begin
    case (sel)
      sam_pkg::SEL_CML: rdData_nxt = cmlMask_r;
      sam_pkg::SEL_OTHER: rdData_nxt = sam_pkg::OTHER_FIXED;
      sam_pkg::SEL_MFR: rdData_nxt = mfrMask_r;
      default: rdData_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdValid_r <= 1'b0;
      rdData_r <= 8'h00;
    end
    else
    begin
      rdValid_r <= rdReq;
      if (rdReq)
        rdData_r <= rdData_nxt;
    end
  end

  // unknown selector or command refused; other-mask write is dropped
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      cmdNack_r <= 1'b0;
    else
      cmdNack_r <= cmdStb && (sel == sam_pkg::SEL_NONE);
  end

  // ************************************
  // save to nonvolatile memory
  // ************************************
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      storeValid_r <= 1'b0;
      storeCml_r <= 8'h00;
      storeMfr_r <= 8'h00;
    end
    else
    begin
      storeValid_r <= nvmStore;
      if (nvmStore)
      begin
        storeCml_r <= cmlMask_r;
        storeMfr_r <= mfrMask_r;
      end
    end
  end

  // ************************************
  // alert
  // ************************************
  // self and sync faults pass like any other unmasked vendor bit
  assign alert_nxt = (|(commLogicStatus & ~cmlMask_r)) ||
                     (|(vendorStatus & ~mfrMask_r));

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      alert_r <= 1'b0;
    else
      alert_r <= alert_nxt;
  end

  // ************************************
  // assertions
  // ************************************
  default clocking cbSys @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  property p_unmaskedRaises;
    (|(commLogicStatus & ~cmlMask_r)) |=> alert_r;
  endproperty
  a_unmaskedRaises: assert property (p_unmaskedRaises)
    else $error("unmasked comm status did not raise alert");

  property p_maskedQuiet;
    (~|(commLogicStatus & ~cmlMask_r)) && (~|(vendorStatus & ~mfrMask_r))
      |=> !alert_r;
  endproperty
  a_maskedQuiet: assert property (p_maskedQuiet)
    else $error("alert raised with all status masked");

  property p_cmlWrite;
    cmlWr && !nvmLoad |=>
      cmlMask_r == ($past(cmdData) & sam_pkg::CML_WR_MASK);
  endproperty
  a_cmlWrite: assert property (p_cmlWrite)
    else $error("comm mask write not taken");

  property p_cmlZero;
    cmlMask_r[3:2] == 2'b00 && cmlMask_r[0] == 1'b0;
  endproperty
  a_cmlZero: assert property (p_cmlZero)
    else $error("comm mask unsupported bits set");

  property p_otherRead;
    rdReq && sel == sam_pkg::SEL_OTHER |=>
      rdValid_r && rdData_r == sam_pkg::OTHER_FIXED;
  endproperty
  a_otherRead: assert property (p_otherRead)
    else $error("other mask read not 01");

  property p_mfrRead;
    rdReq && sel == sam_pkg::SEL_MFR |=> rdData_r == $past(mfrMask_r);
  endproperty
  a_mfrRead: assert property (p_mfrRead)
    else $error("vendor mask read wrong");

  property p_readPulse;
    rdReq && !$past(rdReq) |=> rdValid_r ##1 ($past(rdReq) || !rdValid_r);
  endproperty
  a_readPulse: assert property (p_readPulse)
    else $error("read answer not one cycle");

  property p_mfrZero;
    mfrMask_r[5:4] == 2'b00 && mfrMask_r[0] == 1'b0;
  endproperty
  a_mfrZero: assert property (p_mfrZero)
    else $error("vendor mask unsupported bits set");

  property p_selfAlert;
    vendorStatus[sam_pkg::MFR_SELF_BIT] && !mfrMask_r[sam_pkg::MFR_SELF_BIT]
      |=> alert_r;
  endproperty
  a_selfAlert: assert property (p_selfAlert)
    else $error("self fault did not raise alert");

  property p_syncAlert;
    vendorStatus[sam_pkg::MFR_SYNC_BIT] && !mfrMask_r[sam_pkg::MFR_SYNC_BIT]
      |=> alert_r;
  endproperty
  a_syncAlert: assert property (p_syncAlert)
    else $error("sync fault did not raise alert");

  property p_nvmLoad;
    nvmLoad |=>
      cmlMask_r == ($past(nvmCmlData) & sam_pkg::CML_WR_MASK) &&
      mfrMask_r == ($past(nvmMfrData) & sam_pkg::MFR_WR_MASK);
  endproperty
  a_nvmLoad: assert property (p_nvmLoad)
    else $error("memory load not applied");

  property p_cmlRead;
    rdReq && sel == sam_pkg::SEL_CML |=> rdData_r == $past(cmlMask_r);
  endproperty
  a_cmlRead: assert property (p_cmlRead)
    else $error("comm mask read wrong");

  property p_alertHolds;
    (|(vendorStatus & ~mfrMask_r)) || (|(commLogicStatus & ~cmlMask_r))
      |=> alert_r;
  endproperty
  a_alertHolds: assert property (p_alertHolds)
    else $error("alert dropped while cause stands");

  c_cmlWrite: cover property (cmlWr ##2 rdReq ##1 rdValid_r);
  c_alertMaskOff: cover property (alert_r ##1 mfrWr ##2 !alert_r);
  c_nvmRoundTrip: cover property (nvmLoad ##1 nvmStore ##1 storeValid_r);
endmodule : sam_alert_mask

/* core/sam_pkg.sv */
// Purpose: constants and decode for the alert-mask block
// Assumes: one command at a time from the command decoder
// Notes: used by the mask block, which passes its masks and reset values to the mask register
package sam_pkg;
  // ************************************
  // command and selectors
  // ************************************
  localparam logic [7:0] CMD_ALERT_MASK = 8'h1b;
  localparam logic [7:0] SEL_CML_CODE = 8'h7e;
  localparam logic [7:0] SEL_OTHER_CODE = 8'h7f;
  localparam logic [7:0] SEL_MFR_CODE = 8'h80;
  // ************************************
  // field layouts and reset values
  // ************************************
  localparam logic [7:0] CML_WR_MASK = 8'hf2;
  localparam logic [7:0] MFR_WR_MASK = 8'hce;
  localparam logic [7:0] OTHER_FIXED = 8'h01;
  localparam logic [7:0] CML_RST = 8'hf2;
  localparam logic [7:0] MFR_RST = 8'hce;
  localparam int MFR_SELF_BIT = 6;
  localparam int MFR_SYNC_BIT = 1;

  typedef enum logic [1:0] {SEL_NONE, SEL_CML, SEL_OTHER, SEL_MFR} sam_sel_t;

  function automatic sam_sel_t decodeSel(input logic [7:0] code,
                                         input logic [7:0] sel);
    decodeSel = SEL_NONE;
    if (code == CMD_ALERT_MASK)
    begin
      if (sel == SEL_CML_CODE)
        decodeSel = SEL_CML;
      else if (sel == SEL_OTHER_CODE)
        decodeSel = SEL_OTHER;
      else if (sel == SEL_MFR_CODE)
        decodeSel = SEL_MFR;
    end
  endfunction : decodeSel
endpackage : sam_pkg

/* core/sam_mask_reg.sv */
// Purpose: one 8-bit alert mask with writable and fixed-zero bits
// Assumes: load and write are same-clock pulses
// Notes: load wins over a host write in the same cycle
`timescale 1ns/100ps
module sam_mask_reg #(
  parameter logic [7:0] WR_MASK = 8'hff,
  parameter logic [7:0] RST_VAL = 8'hff
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  input wire logic ldEn,
  input wire logic [7:0] ldData,
  output logic [7:0] value_r
);
  logic [7:0] value_nxt;

  always_comb
  begin
    value_nxt = value_r;
    if (ldEn)
      value_nxt = ldData & WR_MASK;
    else if (wrEn)
      value_nxt = wrData & WR_MASK;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      value_r <= RST_VAL;
    else
      value_r <= value_nxt;
  end
endmodule : sam_mask_reg

/* tb/sam_host.sv */
// Purpose: host side of the alert mask command bus
// Assumes: one command in flight at a time
// Notes: released lines show inverted values, never stale ones
`timescale 1ns/100ps
module sam_host (
  input wire logic clk_sys,
  output logic cmdStb,
  output logic cmdWr,
  output logic [7:0] cmdCode,
  output logic [7:0] cmdSel,
  output logic [7:0] cmdData
);
  initial
  begin
    cmdStb = 1'b0;
    cmdWr = 1'b0;
    cmdCode = 8'h00;
    cmdSel = 8'h00;
    cmdData = 8'h00;
  end

  // ************************************
  // one command: held one edge, then released
  // ************************************
  task automatic send(input logic wr, input logic [7:0] code, sel, dat);
    @(posedge clk_sys);
    cmdStb <= 1'b1;
    cmdWr <= wr;
    cmdCode <= code;
    cmdSel <= sel;
    cmdData <= dat;
    @(posedge clk_sys);
    cmdStb <= 1'b0;
    cmdWr <= ~wr;
    cmdCode <= ~code;
    cmdSel <= ~sel;
    cmdData <= ~dat;
    #1;
  endtask : send
endmodule : sam_host

/* tb/sam_alert_mask_tb.sv */
// Purpose: self-checking bench for the alert mask block
// Assumes: host model drives the command bus
// Notes: rows write a mask, then read it back
`timescale 1ns/100ps
module sam_alert_mask_tb;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic cmdStb, cmdWr, nvmLoad = 1'b0, nvmStore = 1'b0;
  logic [7:0] cmdCode, cmdSel, cmdData;
  logic [7:0] cmlSt = 8'h00, venSt = 8'h00;
  logic [7:0] nvmCml = 8'h00, nvmMfr = 8'h00;
  logic rdValid, nack, stValid, alert;
  logic [7:0] rdData, stCml, stMfr;
  int err_count = 0;
  int num_checks = 0;
  // selector, written value, value read back
  localparam logic [23:0] ROWS [5] = '{24'h7efff2, 24'h7e0c00,
    24'h7fff01, 24'h80ffce, 24'h803100};

  always #50 clk_sys = ~clk_sys;

  sam_host i_host (.clk_sys(clk_sys), .cmdStb(cmdStb), .cmdWr(cmdWr),
    .cmdCode(cmdCode), .cmdSel(cmdSel), .cmdData(cmdData));

  sam_alert_mask i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .cmdStb(cmdStb), .cmdWr(cmdWr), .cmdCode(cmdCode), .cmdSel(cmdSel),
    .cmdData(cmdData), .commLogicStatus(cmlSt), .vendorStatus(venSt),
    .nvmLoad(nvmLoad), .nvmCmlData(nvmCml), .nvmMfrData(nvmMfr),
    .nvmStore(nvmStore), .rdValid_r(rdValid), .rdData_r(rdData),
    .cmdNack_r(nack), .storeValid_r(stValid), .storeCml_r(stCml),
    .storeMfr_r(stMfr), .alert_r(alert));

  // ************************************
  // compares and verdict
  // ************************************
  task automatic chk8(input logic [7:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t byte %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t flag %b exp %b", $time, got, exp);
    end
  endtask : chk1

  task automatic rd(input logic [7:0] sel, exp);
    i_host.send(1'b0, 8'h1b, sel, 8'h00);
    chk1(rdValid, 1'b1);
    chk8(rdData, exp);
  endtask : rd

  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (2000) @(posedge clk_sys);
    err_count++;
    summarize();
  end

  // ************************************
  // main sequence
  // ************************************
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    foreach (ROWS[i])
    begin
      i_host.send(1'b1, 8'h1b, ROWS[i][23:16], ROWS[i][15:8]);
      chk1(nack, 1'b0);
      rd(ROWS[i][23:16], ROWS[i][7:0]);
    end
    i_host.send(1'b0, 8'h1b, 8'h81, 8'h00);
    chk1(nack, 1'b1);
    chk8(rdData, 8'h00);
    i_host.send(1'b1, 8'h1c, 8'h7e, 8'hff);
    chk1(nack, 1'b1);
    rd(8'h7e, 8'h00);
    // mid-run reset: masks fall back to f2 and ce, every writable bit masked
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(8'h7e, 8'hf2);
    rd(8'h80, 8'hce);
    @(posedge clk_sys);
    nvmCml <= 8'h0d;
    nvmMfr <= 8'h08;
    nvmLoad <= 1'b1;
    @(posedge clk_sys);
    nvmLoad <= 1'b0;
    nvmStore <= 1'b1;
    @(posedge clk_sys);
    nvmStore <= 1'b0;
    venSt <= 8'h08;
    #1;
    chk1(stValid, 1'b1);
    chk8(stCml, 8'h00);
    chk8(stMfr, 8'h08);
    tick();
    chk1(alert, 1'b0);
    @(posedge clk_sys);
    venSt <= 8'h42;
    tick();
    chk1(alert, 1'b1);
    i_host.send(1'b1, 8'h1b, 8'h80, 8'h42);
    tick();
    chk1(alert, 1'b0);
    @(posedge clk_sys);
    venSt <= 8'h00;
    cmlSt <= 8'h02;
    tick();
    chk1(alert, 1'b1);
    @(posedge clk_sys);
    cmlSt <= 8'h00;
    tick();
    chk1(alert, 1'b0);
    summarize();
  end
endmodule : sam_alert_mask_tb
